// ### rtl/scan_fault_pkg.sv
package scan_fault_pkg;
    // apb map: printed offsets are indices, byte address is index times four
    localparam int unsigned FAULTS_IDX     = 8;
    localparam int unsigned SLOT_CNT_IDX   = 9;
    localparam int unsigned SLOT_BASE_IDX  = 10;
    localparam int unsigned NUM_SLOTS      = 19;
    localparam logic [11:0] FAULTS_ADDR    = 12'(FAULTS_IDX * 4);
    localparam logic [11:0] SLOT_CNT_ADDR  = 12'(SLOT_CNT_IDX * 4);
    localparam logic [11:0] SLOT_BASE_ADDR = 12'(SLOT_BASE_IDX * 4);
    localparam logic [11:0] SLOT_END_ADDR  = 12'((SLOT_BASE_IDX + NUM_SLOTS) * 4);
    localparam logic [11:0] CTRL_ADDR      = 12'h080;
    localparam logic [11:0] STATUS_ADDR    = 12'h084;
    localparam int unsigned SLOT_AW        = 5;

    // fault byte fields
    localparam int unsigned F_SYNC   = 0;
    localparam int unsigned F_STORE  = 2;
    localparam int unsigned F_WDOG   = 3;
    localparam int unsigned F_REDUN  = 6;
    localparam int unsigned F_TIMING = 7;
    localparam logic [7:0]  FAULT_USED_MASK = 8'hcd;

    // slot status codes
    localparam logic [7:0] SLOT_UNCONF  = 8'h00;
    localparam logic [7:0] SLOT_EMPTY   = 8'h01;
    localparam logic [7:0] SLOT_DISCORD = 8'h02;
    localparam logic [7:0] SLOT_OPER    = 8'h04;
    localparam logic [7:0] SLOT_USERF   = 8'h05;
    localparam logic [7:0] SLOT_FAULT   = 8'hff;

    // control register: protection level
    localparam logic [2:0] PROT_RESET = 3'h3;
    localparam logic [2:0] PROT_LVL1  = 3'h1;
    localparam logic [2:0] PROT_LVL2  = 3'h2;
    localparam logic [2:0] PROT_LVL4  = 3'h4;
    localparam int unsigned PROT_W    = 3;

    // status register fields
    localparam int unsigned ST_MODE_LSB = 0;
    localparam int unsigned ST_DENIED   = 3;
    localparam int unsigned ST_NBFAULT  = 4;
    localparam int unsigned ST_STANDALN = 5;

    // network command opcodes
    localparam logic [2:0] CMD_COMMIT_IDLE  = 3'h1;
    localparam logic [2:0] CMD_COMMIT_READY = 3'h2;
    localparam logic [2:0] CMD_COMMIT_RUN   = 3'h3;
    localparam logic [2:0] CMD_FORCE        = 3'h4;
    localparam logic [2:0] CMD_EXIT_SA      = 3'h5;

    // timing
    localparam longint unsigned CLK_HZ     = 100_000_000;
    localparam longint unsigned TICK_MAX_MS = 10;
    localparam int unsigned TICK_LIMIT_CYC = int'(TICK_MAX_MS * (CLK_HZ / 1000));
    localparam int unsigned TICK_CNT_W     = 21;

    typedef enum logic [2:0] {
        MODE_IDLE,
        MODE_READY,
        MODE_RUN,
        MODE_SA_IDLE,
        MODE_SA_READY
    } mode_t;
endpackage

// ### rtl/slot_status_mem.sv
`timescale 1ns/1ps
module slot_status_mem
    import scan_fault_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               ce,
    input  wire logic               wr_en,
    input  wire logic [SLOT_AW-1:0] wr_addr,
    input  wire logic [7:0]         wr_data,
    input  wire logic [SLOT_AW-1:0] rd_addr,
    output logic      [7:0]         rd_data
);
    logic [7:0] mem [NUM_SLOTS];
    logic [7:0] rd_nxt;

    // read word selection, out of range reads zero
    always_comb begin
        rd_nxt = 8'h00;
        if (32'(rd_addr) < NUM_SLOTS) begin
            rd_nxt = mem[rd_addr];
        end
    end

    // storage array, no reset needed since every slot is rewritten each sweep
    always_ff @(posedge pclk) begin
        if (ce && wr_en && 32'(wr_addr) < NUM_SLOTS) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // registered read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= 8'h00;
        end else if (ce) begin
            rd_data <= rd_nxt;
        end
    end
endmodule // slot_status_mem

// ### rtl/scanner_fault_status.sv
// Behaviour
// [R1] fault bit 0 follows loss of time synchronisation, clears itself on regain
// [R2] fault bit 2 set on failed store, cleared by a later good store
// [R3] fault bit 3 set on watchdog idle, cleared by commit to ready or run
// [R4] fault bit 6 follows loss of redundant medium, clears when both work
// [R5] fault bit 7 set when tick routine exceeds 10 ms, cleared by commit
// [R6] configured slot reports 01 when empty, 02 when module mismatches
// [R7] slot reports 04 when matching module is present and working
// [R8] slot reports 05 on chattering input or module-reported fault
// [R9] slot reports ff when matching module is present but not functional
// [R10] edits in wrong mode or level are denied; any key clears denial
// [R11] terminal reads and changes allowed by default, blocked at level 1 or 2
// [R12] level 4 lets the terminal view and write selected parameters
// [R13] terminal reads are served in every mode
// [R14] edits and forcing only in standalone idle or standalone ready
// [R15] combined mode request: idle to standalone idle, ready to standalone ready
// [R16] standalone modes ignore every network command
// [R17] scanner non-blocking summary set while fault byte is nonzero
// [R18] reserved fault bits read zero and are never set
`timescale 1ns/1ps
module scanner_fault_status
    import scan_fault_pkg::*;
#(
    parameter int unsigned TICK_LIMIT = TICK_LIMIT_CYC
)(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 ce,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 sync_lost_pin,
    input  wire logic                 redun_lost_pin,
    input  wire logic                 wdog_pin,
    input  wire logic                 tick_busy_pin,
    input  wire logic [NUM_SLOTS-1:0] slot_cfg_pin,
    input  wire logic [NUM_SLOTS-1:0] slot_present_pin,
    input  wire logic [NUM_SLOTS-1:0] slot_match_pin,
    input  wire logic [NUM_SLOTS-1:0] slot_ok_pin,
    input  wire logic [NUM_SLOTS-1:0] slot_userf_pin,
    input  wire logic                 store_done,
    input  wire logic                 store_err,
    input  wire logic                 net_cmd_valid,
    input  wire logic [2:0]           net_cmd_op,
    output logic                      net_cmd_ignored,
    output logic                      net_force_ok,
    input  wire logic                 term_key,
    input  wire logic                 term_mode_req,
    input  wire logic                 term_exit_req,
    input  wire logic                 term_read_req,
    input  wire logic                 term_edit_req,
    input  wire logic                 term_param_req,
    input  wire logic                 term_force_req,
    output logic                      term_granted,
    output logic                      term_denied,
    output logic [2:0]                op_mode,
    output logic                      scanner_nb_fault
);
    // two-stage synchronisers for pin inputs
    logic [3:0]           lvl_s1_r, lvl_s2_r;
    logic [NUM_SLOTS-1:0] cfg_s1_r, cfg_s2_r, pres_s1_r, pres_s2_r, match_s1_r, match_s2_r;
    logic [NUM_SLOTS-1:0] ok_s1_r, ok_s2_r, uf_s1_r, uf_s2_r;
    logic                 wdog_d_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_s1_r   <= 4'h0;
            lvl_s2_r   <= 4'h0;
            cfg_s1_r   <= '0;
            cfg_s2_r   <= '0;
            pres_s1_r  <= '0;
            pres_s2_r  <= '0;
            match_s1_r <= '0;
            match_s2_r <= '0;
            ok_s1_r    <= '0;
            ok_s2_r    <= '0;
            uf_s1_r    <= '0;
            uf_s2_r    <= '0;
            wdog_d_r   <= 1'b0;
        end else if (ce) begin
            lvl_s1_r   <= {tick_busy_pin, wdog_pin, redun_lost_pin, sync_lost_pin};
            lvl_s2_r   <= lvl_s1_r;
            cfg_s1_r   <= slot_cfg_pin;
            cfg_s2_r   <= cfg_s1_r;
            pres_s1_r  <= slot_present_pin;
            pres_s2_r  <= pres_s1_r;
            match_s1_r <= slot_match_pin;
            match_s2_r <= match_s1_r;
            ok_s1_r    <= slot_ok_pin;
            ok_s2_r    <= ok_s1_r;
            uf_s1_r    <= slot_userf_pin;
            uf_s2_r    <= uf_s1_r;
            wdog_d_r   <= lvl_s2_r[2];
        end
    end

    logic sync_lost, redun_lost, wdog_evt, tick_busy;
    assign sync_lost  = lvl_s2_r[0];
    assign redun_lost = lvl_s2_r[1];
    assign wdog_evt   = lvl_s2_r[2] & ~wdog_d_r;
    assign tick_busy  = lvl_s2_r[3];

    // operating mode and command handling
    mode_t      mode_r, mode_nxt;
    logic [2:0] prot_r, prot_nxt;
    logic       standalone, cmd_ok, commit_any, commit_go;
    logic       ign_nxt, ign_r, fok_nxt, fok_r;
    logic       grant_nxt, grant_r, deny_nxt, deny_r;
    logic       read_ok, edit_ok, param_ok, edit_try;

    assign standalone = (mode_r == MODE_SA_IDLE) || (mode_r == MODE_SA_READY);
    assign cmd_ok     = net_cmd_valid && !standalone;                      // [R16]
    assign commit_any = cmd_ok && (net_cmd_op == CMD_COMMIT_IDLE ||
                        net_cmd_op == CMD_COMMIT_READY || net_cmd_op == CMD_COMMIT_RUN);
    assign commit_go  = cmd_ok && (net_cmd_op == CMD_COMMIT_READY || net_cmd_op == CMD_COMMIT_RUN);

    // protection and mode gating for terminal access
    assign read_ok  = (prot_r != PROT_LVL1) && (prot_r != PROT_LVL2);      // [R11] [R13]
    assign edit_ok  = read_ok && standalone;                               // [R14]
    assign param_ok = edit_ok && (prot_r == PROT_LVL4);                    // [R12]
    assign edit_try = term_edit_req | term_force_req | term_param_req;

    always_comb begin
        mode_nxt  = mode_r;
        ign_nxt   = net_cmd_valid && standalone;                           // [R16]
        fok_nxt   = cmd_ok && (net_cmd_op == CMD_FORCE);
        grant_nxt = 1'b0;
        deny_nxt  = deny_r;
        if (term_key) begin
            deny_nxt = 1'b0;                                               // [R10]
        end
        unique case (mode_r)
            MODE_IDLE, MODE_READY, MODE_RUN: begin
                if (wdog_evt) begin
                    mode_nxt = MODE_IDLE;
                end else if (term_mode_req && mode_r == MODE_IDLE) begin
                    mode_nxt = MODE_SA_IDLE;                               // [R15]
                end else if (term_mode_req && mode_r == MODE_READY) begin
                    mode_nxt = MODE_SA_READY;                              // [R15]
                end else if (cmd_ok && net_cmd_op == CMD_COMMIT_IDLE) begin
                    mode_nxt = MODE_IDLE;
                end else if (cmd_ok && net_cmd_op == CMD_COMMIT_READY) begin
                    mode_nxt = MODE_READY;
                end else if (cmd_ok && net_cmd_op == CMD_COMMIT_RUN) begin
                    mode_nxt = MODE_RUN;
                end
            end
            MODE_SA_IDLE: begin
                if (term_exit_req) begin
                    mode_nxt = MODE_IDLE;
                end
            end
            MODE_SA_READY: begin
                if (term_exit_req) begin
                    mode_nxt = MODE_READY;
                end
            end
            default: mode_nxt = MODE_IDLE;
        endcase
        if (term_read_req) begin
            grant_nxt = read_ok;                                           // [R13]
            if (!read_ok) begin
                deny_nxt = 1'b1;                                           // [R11]
            end
        end
        if (edit_try) begin
            if ((term_param_req && param_ok) || (!term_param_req && edit_ok)) begin
                grant_nxt = 1'b1;
            end else begin
                grant_nxt = 1'b0;
                deny_nxt  = 1'b1;                                          // [R10]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r  <= MODE_IDLE;
            ign_r   <= 1'b0;
            fok_r   <= 1'b0;
            grant_r <= 1'b0;
            deny_r  <= 1'b0;
        end else if (ce) begin
            mode_r  <= mode_nxt;
            ign_r   <= ign_nxt;
            fok_r   <= fok_nxt;
            grant_r <= grant_nxt;
            deny_r  <= deny_nxt;
        end
    end

    // fault byte with sticky and self-clearing bits, set wins over clear
    logic [7:0]            flt_r, flt_nxt;
    logic [TICK_CNT_W-1:0] tick_cnt_r, tick_cnt_nxt;
    logic                  tick_over;

    assign tick_over = tick_busy && (32'(tick_cnt_r) > TICK_LIMIT);

    always_comb begin
        flt_nxt           = flt_r & FAULT_USED_MASK;                       // [R18]
        tick_cnt_nxt      = tick_cnt_r;
        if (!tick_busy) begin
            tick_cnt_nxt = '0;
        end else if (!tick_over) begin
            tick_cnt_nxt = tick_cnt_r + 1'b1;
        end
        flt_nxt[F_SYNC]   = sync_lost;                                     // [R1]
        flt_nxt[F_REDUN]  = redun_lost;                                    // [R4]
        if (store_done && !store_err) begin
            flt_nxt[F_STORE] = 1'b0;                                       // [R2]
        end
        if (store_err) begin
            flt_nxt[F_STORE] = 1'b1;                                       // [R2]
        end
        if (commit_go) begin
            flt_nxt[F_WDOG] = 1'b0;                                        // [R3]
        end
        if (wdog_evt) begin
            flt_nxt[F_WDOG] = 1'b1;                                        // [R3]
        end
        if (commit_any) begin
            flt_nxt[F_TIMING] = 1'b0;                                      // [R5]
        end
        if (tick_over) begin
            flt_nxt[F_TIMING] = 1'b1;                                      // [R5]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flt_r      <= 8'h00;
            tick_cnt_r <= '0;
        end else if (ce) begin
            flt_r      <= flt_nxt;
            tick_cnt_r <= tick_cnt_nxt;
        end
    end

    // slot sweep: one slot evaluated and stored per cycle
    logic [SLOT_AW-1:0] sweep_r, sweep_nxt;
    logic [7:0]         code;
    logic [7:0]         mem_rd;
    logic [SLOT_AW-1:0] mem_raddr;

    always_comb begin
        sweep_nxt = (32'(sweep_r) == NUM_SLOTS - 1) ? '0 : sweep_r + 1'b1;
        if (!cfg_s2_r[sweep_r]) begin
            code = SLOT_UNCONF;
        end else if (!pres_s2_r[sweep_r]) begin
            code = SLOT_EMPTY;                                             // [R6]
        end else if (!match_s2_r[sweep_r]) begin
            code = SLOT_DISCORD;                                           // [R6]
        end else if (!ok_s2_r[sweep_r]) begin
            code = SLOT_FAULT;                                             // [R9]
        end else if (uf_s2_r[sweep_r]) begin
            code = SLOT_USERF;                                             // [R8]
        end else begin
            code = SLOT_OPER;                                              // [R7]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sweep_r <= '0;
        end else if (ce) begin
            sweep_r <= sweep_nxt;
        end
    end

    assign mem_raddr = SLOT_AW'((paddr - SLOT_BASE_ADDR) >> 2);

    slot_status_mem u_slot_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .wr_en   (1'b1),
        .wr_addr (sweep_r),
        .wr_data (code),
        .rd_addr (mem_raddr),
        .rd_data (mem_rd)
    );

    // apb slave, one wait state on every access
    logic        done_r, done_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        err_r, err_nxt;
    logic        is_slot, mapped, acc;

    assign is_slot = (paddr >= SLOT_BASE_ADDR) && (paddr < SLOT_END_ADDR) && (paddr[1:0] == 2'b00);
    assign mapped  = is_slot || paddr == FAULTS_ADDR || paddr == SLOT_CNT_ADDR ||
                     paddr == CTRL_ADDR || paddr == STATUS_ADDR;
    assign acc     = psel && penable;

    always_comb begin
        done_nxt  = 1'b0;
        rdata_nxt = rdata_r;
        err_nxt   = err_r;
        prot_nxt  = prot_r;
        if (acc && !done_r) begin
            done_nxt  = 1'b1;
            err_nxt   = !mapped;
            rdata_nxt = 32'h0;
            if (!pwrite) begin
                unique case (1'b1)
                    paddr == FAULTS_ADDR:   rdata_nxt = {24'h0, flt_r & FAULT_USED_MASK};  // [R18]
                    paddr == SLOT_CNT_ADDR: rdata_nxt = 32'(NUM_SLOTS);
                    paddr == CTRL_ADDR:     rdata_nxt = {29'h0, prot_r};
                    paddr == STATUS_ADDR:   rdata_nxt = 32'({standalone, scanner_nb_fault, deny_r, op_mode});
                    is_slot:                rdata_nxt = {24'h0, mem_rd};
                    default:                rdata_nxt = 32'h0;
                endcase
            end else if (paddr == CTRL_ADDR) begin
                prot_nxt = pwdata[PROT_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r  <= 1'b0;
            rdata_r <= 32'h0;
            err_r   <= 1'b0;
            prot_r  <= PROT_RESET;
        end else if (ce) begin
            done_r  <= done_nxt;
            rdata_r <= rdata_nxt;
            err_r   <= err_nxt;
            prot_r  <= prot_nxt;
        end
    end

    // outputs
    assign pready           = acc && done_r;
    assign pslverr          = acc && done_r && err_r;
    assign prdata           = rdata_r;
    assign net_cmd_ignored  = ign_r;
    assign net_force_ok     = fok_r;
    assign term_granted     = grant_r;
    assign term_denied      = deny_r;
    assign op_mode          = mode_r;
    assign scanner_nb_fault = |flt_r;                                      // [R17]
endmodule // scanner_fault_status

// ### verif/net_term_model.sv
`timescale 1ns/1ps
module net_term_model (
    input  wire logic pclk,
    output logic       net_cmd_valid,
    output logic [2:0] net_cmd_op,
    output logic [6:0] term_req
);
    // idle far side at time zero
    initial begin
        net_cmd_valid = 1'b0;
        net_cmd_op    = 3'h0;
        term_req      = 7'h00;
    end

    // network master keeps commanding whatever the mode
    task automatic cmd(input logic [2:0] op);
        @(posedge pclk);
        net_cmd_valid <= 1'b1;
        net_cmd_op    <= op;
        @(posedge pclk);
        net_cmd_valid <= 1'b0;
        net_cmd_op    <= ~op;
    endtask

    // one-cycle terminal pulse, bit 1 is the combined mode request
    task automatic key(input int k);
        @(posedge pclk);
        term_req <= 7'(1 << k);
        @(posedge pclk);
        term_req <= 7'h00;
    endtask
endmodule // net_term_model

// ### verif/scanner_fault_status_assertions.sv
`timescale 1ns/1ps
module scanner_fault_status_assertions (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       ce,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       sync_lost_pin,
    input wire logic       redun_lost_pin,
    input wire logic       net_cmd_valid,
    input wire logic       net_cmd_ignored,
    input wire logic       term_key,
    input wire logic       term_mode_req,
    input wire logic       term_exit_req,
    input wire logic       term_read_req,
    input wire logic       term_edit_req,
    input wire logic       term_param_req,
    input wire logic       term_force_req,
    input wire logic       term_granted,
    input wire logic       term_denied,
    input wire logic [2:0] op_mode,
    input wire logic       scanner_nb_fault
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // any terminal request other than a bare key
    wire any_req = term_mode_req | term_exit_req | term_read_req | term_edit_req | term_param_req | term_force_req;

    pready_wait_a: assert property (psel && penable && !pready && ce |=> pready || !psel)
        else $error("no answer after one wait state");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    sync_fault_a: assert property (sync_lost_pin [*4] |-> scanner_nb_fault)
        else $error("sync loss not summarised");
    redun_fault_a: assert property (redun_lost_pin [*4] |-> scanner_nb_fault)
        else $error("redundancy loss not summarised");
    net_ignore_a: assert property (net_cmd_valid && op_mode >= 3'h3 && !term_exit_req
        |=> net_cmd_ignored && op_mode == $past(op_mode))
        else $error("network command obeyed in standalone");
    edit_deny_a: assert property (term_edit_req && op_mode < 3'h3 |=> term_denied && !term_granted)
        else $error("edit outside standalone");
    force_deny_a: assert property (term_force_req && op_mode < 3'h3 |=> term_denied)
        else $error("force outside standalone");
    deny_hold_a: assert property (term_denied && !term_key |=> term_denied)
        else $error("denial dropped without key");
    deny_clear_a: assert property (term_key && !any_req |=> !term_denied)
        else $error("key did not clear denial");
    mode_step_a: assert property (term_mode_req && op_mode < 3'h2 && !net_cmd_valid
        |=> op_mode == $past(op_mode) + 3'h3)
        else $error("mode request went wrong way");

    grant_c: cover property (term_granted);
    ignore_c: cover property (net_cmd_ignored);
    slverr_c: cover property (pslverr);
endmodule // scanner_fault_status_assertions

bind scanner_fault_status scanner_fault_status_assertions u_chk (.*);

// ### verif/scanner_fault_status_test.sv
`timescale 1ns/1ps
module scanner_fault_status_test;
    import scan_fault_pkg::*;
    localparam int unsigned TL = 20;
    localparam logic [7:0] SC [6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'hff};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v;
    logic sync_lost_pin, redun_lost_pin, wdog_pin, tick_busy_pin, store_done, store_err;
    logic net_cmd_valid, net_cmd_ignored, net_force_ok, term_granted, term_denied, scanner_nb_fault;
    logic [NUM_SLOTS-1:0] slot_cfg_pin, slot_present_pin, slot_match_pin, slot_ok_pin, slot_userf_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic [2:0]  net_cmd_op, op_mode;
    logic [6:0]  tr;
    int          mismatches, n_compared;

    scanner_fault_status #(.TICK_LIMIT(TL)) dut (.*, .ce(1'b1), .term_key(tr[0]), .term_mode_req(tr[1]),
        .term_exit_req(tr[2]), .term_read_req(tr[3]), .term_edit_req(tr[4]), .term_param_req(tr[5]),
        .term_force_req(tr[6]));
    net_term_model u_far (.pclk(pclk), .net_cmd_valid(net_cmd_valid), .net_cmd_op(net_cmd_op), .term_req(tr));

    always #5 pclk = ~pclk;

    task automatic end_of_test;
        if (mismatches == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask

    // apb transfer, held until pready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_v    = prdata;
        err_v   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd_v, e);
    endtask

    // terminal pulse, then granted/denied pair
    task automatic tk(input int k, input logic [1:0] e);
        u_far.key(k);
        #1;
        chk({30'h0, term_granted, term_denied}, {30'h0, e});
    endtask

    task automatic nc(input logic [2:0] op, input logic e);
        u_far.cmd(op);
        #1;
        chk({30'h0, net_cmd_ignored, net_force_ok}, {30'h0, e, !e && op == CMD_FORCE});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    initial begin
        #100us;
        mismatches++;
        end_of_test();
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {sync_lost_pin, redun_lost_pin, wdog_pin, tick_busy_pin, store_done, store_err} = '0;
        {slot_cfg_pin, slot_present_pin, slot_match_pin} = {19'h3e, 19'h3c, 19'h38};
        {slot_ok_pin, slot_userf_pin} = {19'h18, 19'h10};
        cyc(6);
        presetn <= 1'b1;
        cyc(40);
        rd(STATUS_ADDR, 32'h0);
        rd(CTRL_ADDR, {29'h0, PROT_RESET});
        rd(SLOT_CNT_ADDR, 32'd19);
        apb(1'b1, FAULTS_ADDR, 32'hff);
        rd(FAULTS_ADDR, 32'h0);
        rd(12'h100, 32'h0);
        chk({31'h0, err_v}, 32'h1);
        for (int i = 0; i < 6; i++) begin
            rd(SLOT_BASE_ADDR + 12'(4 * i), {24'h0, SC[i]});
        end
        rd(SLOT_BASE_ADDR + 12'd72, 32'h0);
        sync_lost_pin  <= 1'b1;
        redun_lost_pin <= 1'b1;
        cyc(5);
        rd(FAULTS_ADDR, 32'h41);
        rd(STATUS_ADDR, 32'h10);
        sync_lost_pin <= 1'b0;
        cyc(5);
        rd(FAULTS_ADDR, 32'h40);
        redun_lost_pin <= 1'b0;
        cyc(5);
        rd(FAULTS_ADDR, 32'h0);
        store_err <= 1'b1;
        cyc(1);
        store_err <= 1'b0;
        cyc(3);
        rd(FAULTS_ADDR, 32'h4);
        store_done <= 1'b1;
        cyc(1);
        store_done <= 1'b0;
        cyc(3);
        rd(FAULTS_ADDR, 32'h0);
        nc(CMD_COMMIT_READY, 1'b0);
        wdog_pin <= 1'b1;
        cyc(5);
        wdog_pin <= 1'b0;
        rd(STATUS_ADDR, 32'h10);
        nc(CMD_COMMIT_IDLE, 1'b0);
        rd(FAULTS_ADDR, 32'h8);
        nc(CMD_COMMIT_READY, 1'b0);
        rd(FAULTS_ADDR, 32'h0);
        tick_busy_pin <= 1'b1;
        cyc(TL - 4);
        tick_busy_pin <= 1'b0;
        cyc(4);
        rd(FAULTS_ADDR, 32'h0);
        tick_busy_pin <= 1'b1;
        cyc(TL + 8);
        tick_busy_pin <= 1'b0;
        cyc(4);
        rd(FAULTS_ADDR, 32'h80);
        nc(CMD_COMMIT_RUN, 1'b0);
        rd(STATUS_ADDR, 32'h2);
        nc(CMD_COMMIT_IDLE, 1'b0);
        nc(CMD_FORCE, 1'b0);
        tk(4, 2'b01);
        rd(STATUS_ADDR, 32'h8);
        tk(0, 2'b00);
        tk(3, 2'b10);
        tk(6, 2'b01);
        tk(0, 2'b00);
        u_far.key(1);
        rd(STATUS_ADDR, 32'h23);
        tk(4, 2'b10);
        tk(6, 2'b10);
        nc(CMD_EXIT_SA, 1'b1);
        nc(CMD_FORCE, 1'b1);
        rd(STATUS_ADDR, 32'h23);
        apb(1'b1, CTRL_ADDR, {29'h0, PROT_LVL1});
        tk(3, 2'b01);
        tk(0, 2'b00);
        apb(1'b1, CTRL_ADDR, {29'h0, PROT_LVL2});
        tk(4, 2'b01);
        tk(0, 2'b00);
        apb(1'b1, CTRL_ADDR, {29'h0, PROT_LVL4});
        tk(5, 2'b10);
        apb(1'b1, CTRL_ADDR, {29'h0, PROT_RESET});
        tk(5, 2'b01);
        tk(0, 2'b00);
        u_far.key(2);
        nc(CMD_COMMIT_READY, 1'b0);
        u_far.key(1);
        rd(STATUS_ADDR, 32'h24);
        end_of_test();
    end
endmodule // scanner_fault_status_test
